// ### logic/rcs_sequencer.sv
// Reset stretcher, clock divide control, strap capture and pin group control
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module rcs_sequencer (
    // Clock and system reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Board pins
    input  wire logic        reset_pin_n,
    input  wire logic        clock_mode_select,
    input  wire logic [15:0] host_data_lines,
    input  wire logic        ext_mem_clock_in,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    // Internal reset and clock ticks
    output      logic        internal_rst,
    output      logic        processor_sys_clock,
    output      logic        peripheral_sys_clock,
    output      logic        memory_sys_clock,
    // Clock pins
    output      logic        memory_clock_out,
    output      logic        second_clock_out,
    output      logic        second_clock_valid,
    output      logic        third_clock_out,
    // Pin group enables
    output      logic        ext_mem_bus_oe,
    output      logic        bus_request_valid,
    output      logic        serial_timer_oe,
    output      logic        host_gpio_oe,
    // Captured straps and PLL state
    output      logic        big_endian,
    output      logic [1:0]  boot_mode,
    output      logic        pll_bypass
);
    import rcs_pkg::*;

    rcs_phase_t phase_q;
    logic [9:0] stretch_q;
    logic       pin_q;
    logic       pin_rise;
    logic       big_endian_q;
    logic [1:0] boot_mode_q;
    logic       mode_q;
    logic       src_sel_q;
    logic       pll_bypass_q;
    logic       mem_pin_q;
    logic [31:0] prdata_q;
    logic       mapped;
    logic       wr_ctrl;
    logic       proc_wave;
    logic       periph_wave;
    logic       mem_wave;
    logic       third_wave;
    logic       third_tick;
    logic [10:0] hold_cnt_q;

    // Assertion without waiting for an edge: the pin term is combinational
    assign internal_rst = !reset_pin_n || (phase_q != RCS_PH_RUN);
    assign pin_rise     = reset_pin_n && !pin_q;

    // Reset to the pin's idle level, so a pin already high after a system reset
    // is not taken for a fresh rising edge that would latch host traffic as straps
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= reset_pin_n;
        end
    end

    // Stretch counter: the cycle that first sees the pin high counts as one
    always_ff @(posedge clk) begin
        if (sys_rst || !reset_pin_n) begin
            phase_q   <= RCS_PH_PIN;
            stretch_q <= 10'h000;
        end else begin
            case (phase_q)
                RCS_PH_PIN: begin
                    phase_q   <= RCS_PH_STRETCH;
                    stretch_q <= STRETCH_FIRST;
                end
                RCS_PH_STRETCH: begin
                    if (stretch_q == STRETCH_LAST) begin
                        phase_q <= RCS_PH_RUN;
                    end
                    stretch_q <= stretch_q + 10'h001;
                end
                RCS_PH_RUN: begin
                    phase_q <= RCS_PH_RUN;
                end
                default: begin
                    phase_q <= RCS_PH_PIN;
                end
            endcase
        end
    end

    // Straps are sampled on the pin's rising edge; board must hold them then
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            big_endian_q <= 1'b0;
            boot_mode_q  <= 2'b00;
            mode_q       <= 1'b0;
        end else if (pin_rise) begin
            big_endian_q <= host_data_lines[STRAP_ENDIAN];
            boot_mode_q  <= host_data_lines[STRAP_BOOT_HI:STRAP_BOOT_LO];
            mode_q       <= clock_mode_select;
        end
    end

    assign big_endian = big_endian_q;
    assign boot_mode  = boot_mode_q;

    // Clock dividers: divide-by-8 whenever the internal reset is in force
    rcs_clk_div #(
        .NORMAL_RATIO (RATIO_PROC)
    ) u_proc_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .slow    (internal_rst),
        .tick    (processor_sys_clock),
        .wave    (proc_wave)
    );

    rcs_clk_div #(
        .NORMAL_RATIO (RATIO_PERIPH)
    ) u_periph_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .slow    (internal_rst),
        .tick    (peripheral_sys_clock),
        .wave    (periph_wave)
    );

    rcs_clk_div #(
        .NORMAL_RATIO (RATIO_MEM)
    ) u_mem_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .slow    (internal_rst),
        .tick    (memory_sys_clock),
        .wave    (mem_wave)
    );

    rcs_clk_div #(
        .NORMAL_RATIO (RATIO_THIRD)
    ) u_third_div (
        .clk     (clk),
        .sys_rst (sys_rst),
        .slow    (internal_rst),
        .tick    (third_tick),
        .wave    (third_wave)
    );

    // Memory clock pin follows its source as soon as the pin is released
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_pin_q <= 1'b0;
        end else if (src_sel_q == 1'b0) begin
            mem_pin_q <= mem_wave;
        end else begin
            mem_pin_q <= ext_mem_clock_in;
        end
    end

    // Forced low with the pin itself, not a clock later
    assign memory_clock_out   = mem_pin_q && reset_pin_n;
    assign third_clock_out    = third_wave && reset_pin_n;
    assign second_clock_valid = !internal_rst;
    assign second_clock_out   = periph_wave && !internal_rst;

    // Pin groups float or go invalid at once and return with the internal reset
    assign ext_mem_bus_oe    = !internal_rst;
    assign bus_request_valid = !internal_rst;
    assign serial_timer_oe   = !internal_rst;
    assign host_gpio_oe      = !internal_rst;

    // APB slave: zero-wait access phase, read data latched in setup
    assign mapped  = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
    assign wr_ctrl = psel && penable && pwrite && (paddr == CTRL_OFFSET);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    // Control reverts to defaults under any reset, so the PLL leaves reset bypassed
    always_ff @(posedge clk) begin
        if (sys_rst || internal_rst) begin
            src_sel_q    <= SRC_SEL_RESET;
            pll_bypass_q <= PLL_BYP_RESET;
        end else if (wr_ctrl) begin
            src_sel_q    <= pwdata[CTRL_SRC_BIT];
            pll_bypass_q <= pwdata[CTRL_BYP_BIT];
        end
    end

    assign pll_bypass = pll_bypass_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= 32'h0000_0000;
            if (paddr == CTRL_OFFSET) begin
                prdata_q[CTRL_SRC_BIT] <= src_sel_q;
                prdata_q[CTRL_BYP_BIT] <= pll_bypass_q;
            end else if (paddr == STATUS_OFFSET) begin
                prdata_q[ST_IRST_BIT]                <= internal_rst;
                prdata_q[ST_PHASE_LO+1:ST_PHASE_LO]  <= phase_q;
                prdata_q[ST_ENDIAN_BIT]              <= big_endian_q;
                prdata_q[ST_BOOT_LO+1:ST_BOOT_LO]    <= boot_mode_q;
                prdata_q[ST_MODE_BIT]                <= mode_q;
            end
        end
    end

    // Helper for checks: cycles with the pin high while internal reset holds
    always_ff @(posedge clk) begin
        if (sys_rst || !reset_pin_n || !internal_rst) begin
            hold_cnt_q <= 11'h000;
        end else begin
            hold_cnt_q <= hold_cnt_q + 11'h001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_pin_release;
        !reset_pin_n ##1 reset_pin_n;
    endsequence

    sequence s_stretch_hold;
        internal_rst [*8];
    endsequence

    a_stretch_length: assert property (
        reset_pin_n && $fell(internal_rst) && mode_q |-> hold_cnt_q == 11'h200)
        else $error("internal reset not stretched 512 cycles");

    a_stretch_min: assert property (
        s_pin_release |-> s_stretch_hold)
        else $error("internal reset released early");

    a_proc_slow: assert property (
        internal_rst && processor_sys_clock && $past(internal_rst)
        |=> !(processor_sys_clock && internal_rst) [*7])
        else $error("processor clock not divided by 8 in reset");

    a_proc_full: assert property (
        !internal_rst && $past(!internal_rst) |-> processor_sys_clock)
        else $error("processor clock not at full rate");

    a_periph_half: assert property (
        !internal_rst && $past(!internal_rst, 2) && peripheral_sys_clock
        |=> !peripheral_sys_clock ##1 (peripheral_sys_clock || internal_rst))
        else $error("peripheral clock not divided by 2");

    a_mem_half: assert property (
        !internal_rst && $past(!internal_rst, 2) && memory_sys_clock
        |=> !memory_sys_clock ##1 (memory_sys_clock || internal_rst))
        else $error("memory clock source not divided by 2");

    a_pins_float: assert property (
        !reset_pin_n |-> !ext_mem_bus_oe && !serial_timer_oe && !host_gpio_oe
                         && !bus_request_valid)
        else $error("pin group driven while reset pin low");

    a_clk_pins_low: assert property (
        !reset_pin_n |-> !memory_clock_out && !third_clock_out && !second_clock_valid)
        else $error("clock pin active while reset pin low");

    a_strap_capture: assert property (
        $rose(reset_pin_n) |=> boot_mode == $past(host_data_lines[4:3])
                               && big_endian == $past(host_data_lines[8]))
        else $error("straps not captured on reset release");

    a_pll_bypass: assert property (
        $fell(internal_rst) |-> pll_bypass)
        else $error("PLL not bypassed after reset");

    a_mem_src: assert property (
        reset_pin_n && !src_sel_q && $past(reset_pin_n) && $past(!src_sel_q)
        |-> memory_clock_out == $past(mem_wave))
        else $error("memory clock pin not following its source");

    a_groups_valid: assert property (
        $fell(internal_rst) |-> ext_mem_bus_oe && bus_request_valid && second_clock_valid)
        else $error("pin groups not valid after internal reset");

endmodule : rcs_sequencer

// ### logic/rcs_pkg.sv
// Package with constants and types for the reset and clock sequencer
//
// Contract
// - With clock mode select high, internal reset stretches exactly 512 input clocks.
// - While the reset pin is low, all internal clocks run at input divided by 8.
// - During the stretched reset, all clocks stay at input divided by 8.
// - Once fully out of reset, the processor clock runs at full input rate.
// - After reset, the peripheral clock defaults to input divided by 2.
// - After reset, the memory clock source defaults to input divided by 2.
// - After reset, the third clock output toggles at input divided by 8.
// - Source select 0 puts the memory clock source on the memory clock pin.
// - Host data lines 8, 4 and 3 are captured as the reset pin rises.
// - PLL is bypassed on leaving reset; software may change it later.
// - Reset pin low floats the external memory bus group and hold acknowledge.
// - Reset pin low makes the bus request output invalid.
// - Reset pin low floats serial port and timer output pins.
// - Reset pin low floats remaining host port and general purpose pins.
// - Reset pin low drives the memory clock pin low.
// - Reset pin low drives the third clock pin low.
// - Reset pin low makes the second clock pin invalid.
// - Memory clock pin is valid within six processor clocks after pin release.
// - All output groups become valid when the stretched internal reset releases.
// - Board holds strap levels: line 8 endianness, lines 4 and 3 boot mode.
package rcs_pkg;

    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned STRETCH_CYC     = 512;
    localparam logic [9:0]  STRETCH_LAST    = 10'h1ff;
    localparam logic [9:0]  STRETCH_FIRST   = 10'h001;

    localparam logic [3:0]  RATIO_RESET     = 4'h8;
    localparam logic [3:0]  RATIO_PROC      = 4'h1;
    localparam logic [3:0]  RATIO_PERIPH    = 4'h2;
    localparam logic [3:0]  RATIO_MEM       = 4'h2;
    localparam logic [3:0]  RATIO_THIRD     = 4'h8;

    localparam int unsigned STRAP_ENDIAN    = 8;
    localparam int unsigned STRAP_BOOT_HI   = 4;
    localparam int unsigned STRAP_BOOT_LO   = 3;

    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
    localparam int unsigned CTRL_SRC_BIT    = 0;
    localparam int unsigned CTRL_BYP_BIT    = 1;
    localparam logic        SRC_SEL_RESET   = 1'b0;
    localparam logic        PLL_BYP_RESET   = 1'b1;

    localparam int unsigned ST_IRST_BIT     = 0;
    localparam int unsigned ST_PHASE_LO     = 1;
    localparam int unsigned ST_ENDIAN_BIT   = 3;
    localparam int unsigned ST_BOOT_LO      = 4;
    localparam int unsigned ST_MODE_BIT     = 6;

    typedef enum logic [1:0] {
        RCS_PH_PIN     = 2'b00,
        RCS_PH_STRETCH = 2'b01,
        RCS_PH_RUN     = 2'b10
    } rcs_phase_t;

endpackage : rcs_pkg

// ### logic/rcs_clk_div.sv
// Clock divider giving a one-cycle tick and a square wave, slowed to divide-by-8 in reset
`timescale 1ns/1ps
module rcs_clk_div #(
    parameter logic [3:0] NORMAL_RATIO = 4'h1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Control
    input  wire logic slow,
    // Divided clock
    output      logic tick,
    output      logic wave
);
    import rcs_pkg::*;

    logic [3:0] ratio;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       wave_q;

    // Counter wraps early when the ratio shrinks, so no long gap on the switch
    assign ratio = slow ? RATIO_RESET : NORMAL_RATIO;
    assign tick  = (cnt_q >= ratio - 4'h1);
    assign cnt_d = tick ? 4'h0 : cnt_q + 4'h1;
    assign wave  = wave_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= (cnt_d < (ratio >> 1)) || (ratio == 4'h1);
        end
    end

endmodule : rcs_clk_div

// ### testbench/rcs_board_model.sv
// Board reset source and strap resistors facing the sequencer
`timescale 1ns/1ps
module rcs_board_model (
    // Clock
    input  wire logic        clk,
    // Bench commands
    input  wire logic        hold_low,
    input  wire logic [2:0]  strap,
    input  wire logic        mode,
    // Board pins
    output      logic        reset_pin_n,
    output      logic        clock_mode_select,
    output      logic [15:0] host_data_lines,
    output      logic        ext_mem_clock_in
);
    logic [4:0]  hold_q = 5'h00;
    logic        tgl_q  = 1'b0;
    logic [15:0] word;

    assign word = {7'h00, strap[2], 3'h0, strap[1:0], 3'h0};
    assign reset_pin_n = ~hold_low;
    assign clock_mode_select = mode;
    assign ext_mem_clock_in = tgl_q;
    // Straps hold only briefly after release, then the lines carry host traffic
    assign host_data_lines = (hold_low || hold_q != 5'h00) ? word :
                             (word ^ 16'h0118 ^ ({16{tgl_q}} & 16'hfee7));

    always_ff @(posedge clk) begin
        hold_q <= hold_low ? 5'h10 : (hold_q != 5'h00 ? hold_q - 5'h01 : 5'h00);
        tgl_q  <= ~tgl_q;
    end
endmodule : rcs_board_model

// ### testbench/reset_clock_sequencer_tb_top.sv
// Self-checking bench for the reset and clock sequencer
`timescale 1ns/1ps
module reset_clock_sequencer_tb_top;
    import rcs_pkg::*;
    logic        clk = 1'b0, sys_rst = 1'b1, hold_low = 1'b1, mode = 1'b1;
    logic [2:0]  strap = 3'h0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic        e, reset_pin_n, clock_mode_select, ext_mem_clock_in, pready, pslverr;
    logic [15:0] host_data_lines;
    logic        internal_rst, processor_sys_clock, peripheral_sys_clock, memory_sys_clock;
    logic        memory_clock_out, second_clock_out, second_clock_valid, third_clock_out;
    logic        ext_mem_bus_oe, bus_request_valid, serial_timer_oe, host_gpio_oe;
    logic        big_endian, pll_bypass;
    logic [1:0]  boot_mode;
    logic [7:0]  p, r, m, t, ec;
    int          error_cnt = 0, n_compared = 0, i, k, n;
    // Row: mode, endian, boot, then expected status bits 6:0
    logic [10:0] rows [5] = '{{4'h8, 7'h44}, {4'hd, 7'h5c}, {4'ha, 7'h64},
                              {4'hf, 7'h7c}, {4'h6, 7'h2c}};

    always #25 clk = ~clk;

    rcs_board_model rcs_board_model_inst (.clk, .hold_low, .strap, .mode, .reset_pin_n,
        .clock_mode_select, .host_data_lines, .ext_mem_clock_in);
    rcs_sequencer rcs_sequencer_inst (.clk, .sys_rst, .reset_pin_n, .clock_mode_select,
        .host_data_lines, .ext_mem_clock_in, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .internal_rst, .processor_sys_clock,
        .peripheral_sys_clock, .memory_sys_clock, .memory_clock_out, .second_clock_out,
        .second_clock_valid, .third_clock_out, .ext_mem_bus_oe, .bus_request_valid,
        .serial_timer_oe, .host_gpio_oe, .big_endian, .boot_mode, .pll_bypass);

    task end_sim;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin error_cnt++; end_sim; end
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task run16;
        p = 0; r = 0; m = 0; t = 0; ec = 0;
        repeat (16) begin
            @(negedge clk);
            p = p + {7'h0, processor_sys_clock};
            r = r + {7'h0, peripheral_sys_clock};
            m = m + {7'h0, memory_sys_clock};
            t = t + {7'h0, third_clock_out};
            ec = ec + {7'h0, memory_clock_out};
        end
    endtask : run16

    task wait_run;
        for (k = 0; k < 1200; k++) begin
            @(negedge clk);
            if (internal_rst === 1'b0) break;
        end
        if (k == 1200) begin error_cnt++; end_sim; end
    endtask : wait_run

    task pin_pulse(input logic [3:0] s);
        @(posedge clk);
        hold_low <= 1'b1; mode <= s[3]; strap <= s[2:0];
        @(negedge clk);
        chk({internal_rst, ext_mem_bus_oe, bus_request_valid, serial_timer_oe, host_gpio_oe},
            32'h10);
        chk({memory_clock_out, third_clock_out, second_clock_valid}, 32'h0);
        run16;
        chk({p, r, m}, 32'h020202);
        chk({t, ec}, 32'h0);
        @(posedge clk);
        hold_low <= 1'b0;
        p = 0; ec = 0; n = 0;
        for (k = 0; k < 600; k++) begin
            @(negedge clk);
            if (internal_rst !== 1'b1) break;
            n++;
            if (k < 16) p = p + {7'h0, processor_sys_clock};
            if (k < 48) ec = ec + {7'h0, memory_clock_out};
        end
        chk(32'(n), 32'(STRETCH_CYC));
        if (k == 600) begin error_cnt++; end_sim; end
        chk(32'(p), 32'h2);
        chk(32'(ec != 8'h0), 32'h1);
        chk({ext_mem_bus_oe, bus_request_valid, serial_timer_oe, host_gpio_oe,
             second_clock_valid, pll_bypass}, 32'h3f);
        chk({big_endian, boot_mode}, 32'(s[2:0]));
        // Memory clock pin is registered: skip the one cycle still showing the slow wave
        @(negedge clk);
        run16;
        chk({p, r, m}, 32'h100808);
        chk({t, ec}, 32'h0808);
    endtask : pin_pulse

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 5; i++) begin
            pin_pulse(rows[i][10:7]);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk(q, {25'h0, rows[i][6:0]});
        end
        // Control writes during the stretch must be dropped
        @(posedge clk);
        hold_low <= 1'b1;
        repeat (4) @(posedge clk);
        hold_low <= 1'b0;
        apb(1'b1, CTRL_OFFSET, 32'h0);
        wait_run;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(q, 32'h2);
        apb(1'b1, CTRL_OFFSET, 32'h1);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // System reset in mid-run restarts the sequence with defaults
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk({internal_rst, ext_mem_bus_oe}, 32'h2);
        @(posedge clk);
        sys_rst <= 1'b0;
        wait_run;
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(q, 32'h2);
        end_sim;
    end
endmodule : reset_clock_sequencer_tb_top
